// *** design/toip_top.v ***
`timescale 1ns/1ns
`default_nettype none
`include "toip_regs.vh"

module toip_top (
  input  wire       clk_sys,
  input  wire       nrst,
  output reg        overhead_port_clock,
  output reg        overhead_accept_window,
  output reg        overhead_frame_marker,
  input  wire       overhead_serial_in,
  input  wire       overhead_insert_request,
  input  wire       tx_frame_start,
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  input  wire       tx_toh_byte,
  input  wire [1:0] tx_sts_sel,
  input  wire [4:0] tx_toh_idx,
  output reg        tx_out_valid,
  output reg  [7:0] tx_out_data
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_s1;
  reg rst_n;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg bit_s1;
  reg bit_s2;
  reg req_s1;
  reg req_s2;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_s1 <= 1'b0;
      bit_s2 <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      bit_s1 <= overhead_serial_in;
      bit_s2 <= bit_s1;
      req_s1 <= overhead_insert_request;
      req_s2 <= req_s1;
    end
  end

  // ----------------------------------------------------------------
  // Port clock divider
  // ----------------------------------------------------------------
  // Divide by eight so the synchronised pin is settled well before
  // the capture phase, two cycles after the rising edge.
  reg [2:0] phase;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase               <= `TOIP_PH_ZERO;
      overhead_port_clock <= 1'b0;
    end else begin
      phase <= phase + 1'b1;
      if (phase == `TOIP_PH_LAST) begin
        overhead_port_clock <= 1'b1;
      end else if (phase == `TOIP_PH_HIGH_END) begin
        overhead_port_clock <= 1'b0;
      end
    end
  end

  wire at_fall = (phase == `TOIP_PH_FALL);
  wire at_cap  = (phase == `TOIP_PH_CAP);

  // ----------------------------------------------------------------
  // Frame slot counter and port outputs
  // ----------------------------------------------------------------
  reg        synced;
  reg  [8:0] slot;
  reg        byte_ok;
  reg  [8:0] next_slot;
  wire       fifo_in_ready;

  always @* begin
    if (slot == `TOIP_SLOT_LAST) begin
      next_slot = `TOIP_SLOT_ZERO;
    end else begin
      next_slot = slot + 1'b1;
    end
  end

  wire next_in_toh = (next_slot < `TOIP_TOH_BITS);
  wire next_first  = (next_slot[`TOIP_SLOT_BIT] == `TOIP_BIT_FIRST);
  // Reserve a buffer entry for the whole byte before opening it
  wire next_ok     = next_first ? fifo_in_ready : byte_ok;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      synced                 <= 1'b0;
      slot                   <= `TOIP_SLOT_ZERO;
      byte_ok                <= 1'b0;
      overhead_accept_window <= 1'b0;
      overhead_frame_marker  <= 1'b0;
    end else begin
      if (!synced) begin
        if (tx_frame_start) begin
          synced <= 1'b1;
          slot   <= `TOIP_SLOT_SYNC;
        end
      end else if (at_fall) begin
        slot                   <= next_slot;
        byte_ok                <= next_ok;
        overhead_accept_window <= next_in_toh && next_ok;
        overhead_frame_marker  <= (next_slot == `TOIP_SLOT_LAST);
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit capture and byte assembly
  // ----------------------------------------------------------------
  reg  [7:0] acc_data;
  reg  [7:0] acc_mask;
  reg        push;
  reg  [4:0] push_idx;
  // Capture is late by the synchroniser depth, still inside the high phase
  wire       take     = at_cap && overhead_accept_window;
  wire       take_bit = req_s2;
  wire [7:0] new_data = {acc_data[`TOIP_ACC_KEEP], take_bit & bit_s2};
  wire [7:0] new_mask = {acc_mask[`TOIP_ACC_KEEP], take_bit};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_data <= `TOIP_BYTE_ZERO;
      acc_mask <= `TOIP_BYTE_ZERO;
      push     <= 1'b0;
      push_idx <= `TOIP_IDX_ZERO;
    end else begin
      push <= 1'b0;
      if (take) begin
        acc_data <= new_data;
        acc_mask <= new_mask;
        if (slot[`TOIP_SLOT_BIT] == `TOIP_BIT_LAST) begin
          push     <= (new_mask != `TOIP_BYTE_ZERO);
          push_idx <= slot[`TOIP_SLOT_BYTE];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Insert buffer
  // ----------------------------------------------------------------
  wire                    head_valid;
  wire                    head_take;
  wire [`TOIP_FIFO_W-1:0] head;

  toip_fifo #(
    .WIDTH  (`TOIP_FIFO_W),
    .DEPTH  (`TOIP_FIFO_D),
    .ADDR_W (`TOIP_FIFO_AW)
  ) toip_fifo_inst (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_idx, acc_mask, acc_data}),
    .out_valid (head_valid),
    .out_ready (head_take),
    .out_data  (head)
  );

  // ----------------------------------------------------------------
  // Outgoing stream merge
  // ----------------------------------------------------------------
  // A head whose index never comes round stalls the buffer; the
  // stream revisits every index each frame, so this only delays.
  wire [4:0] head_idx  = head[`TOIP_HEAD_IDX];
  wire [7:0] head_mask = head[`TOIP_HEAD_MASK];
  wire [7:0] head_data = head[`TOIP_HEAD_DATA];

  assign head_take = tx_valid && tx_toh_byte && head_valid &&
                     (tx_sts_sel == `TOIP_STS_FIRST) &&
                     (head_idx == tx_toh_idx);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_valid <= 1'b0;
      tx_out_data  <= `TOIP_BYTE_ZERO;
    end else begin
      tx_out_valid <= tx_valid;
      if (head_take) begin
        tx_out_data <= (tx_data & ~head_mask) | (head_data & head_mask);
      end else begin
        tx_out_data <= tx_data;
      end
    end
  end

endmodule

`default_nettype wire

// *** design/toip_regs.vh ***
`ifndef TOIP_REGS_VH
`define TOIP_REGS_VH

// ----------------------------------------------------------------
// Port clock divider, in system clock phases
// ----------------------------------------------------------------
`define TOIP_PH_LAST     3'h7
`define TOIP_PH_HIGH_END 3'h3
`define TOIP_PH_CAP      3'h2
`define TOIP_PH_FALL     3'h4
`define TOIP_PH_ZERO     3'h0

// ----------------------------------------------------------------
// Port frame layout, in port clock periods
// ----------------------------------------------------------------
`define TOIP_SLOT_LAST   9'h137
`define TOIP_SLOT_SYNC   9'h136
`define TOIP_SLOT_ZERO   9'h000
`define TOIP_TOH_BITS    9'h0d8
`define TOIP_BIT_LAST    3'h7
`define TOIP_BIT_FIRST   3'h0
`define TOIP_STS_FIRST   2'h0

// ----------------------------------------------------------------
// Insert buffer word: {byte index, bit mask, bit data}
// ----------------------------------------------------------------
`define TOIP_FIFO_W      21
`define TOIP_FIFO_D      8
`define TOIP_FIFO_AW     3
`define TOIP_BYTE_ZERO   8'h00
`define TOIP_IDX_ZERO    5'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TOIP_SLOT_BIT    2:0
`define TOIP_SLOT_BYTE   7:3
`define TOIP_ACC_KEEP    6:0
`define TOIP_HEAD_IDX    20:16
`define TOIP_HEAD_MASK   15:8
`define TOIP_HEAD_DATA   7:0

`endif

// *** design/toip_fifo.v ***
`timescale 1ns/1ns
`default_nettype none

module toip_fifo #(
  parameter WIDTH  = 21,
  parameter DEPTH  = 8,
  parameter ADDR_W = 3
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W:0]  wr_ptr;
  reg [ADDR_W:0]  rd_ptr;

  wire empty = (wr_ptr == rd_ptr);
  wire full  = (wr_ptr[ADDR_W] != rd_ptr[ADDR_W]) &&
               (wr_ptr[ADDR_W-1:0] == rd_ptr[ADDR_W-1:0]);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[ADDR_W-1:0]];

  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr[ADDR_W-1:0]] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {(ADDR_W+1){1'b0}};
      rd_ptr <= {(ADDR_W+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** test/toip_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module toip_checker (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       overhead_port_clock,
  input wire logic       overhead_accept_window,
  input wire logic       overhead_frame_marker,
  input wire logic       tx_valid,
  input wire logic       tx_toh_byte,
  input wire logic [1:0] tx_sts_sel,
  input wire logic [7:0] tx_data,
  input wire logic       tx_out_valid,
  input wire logic [7:0] tx_out_data
);
  wire logic pc = overhead_port_clock;
  wire logic win = overhead_accept_window;
  wire logic mk = overhead_frame_marker;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_PCLK_SHAPE: assert property (
    $rose(pc) |-> pc[*4] ##1 !pc[*4] ##1 pc) else $error("port clock shape wrong");
  // Window and marker follow the fall by one system cycle
  AST_WIN_AT_FALL: assert property (
    $changed(win) |-> !pc && !$past(pc) && $past(pc, 2)) else $error("window moved off the fall");
  AST_MARK_AT_FALL: assert property (
    $changed(mk) |-> !pc && !$past(pc) && $past(pc, 2)) else $error("marker moved off the fall");
  AST_MARK_LEN: assert property (
    $rose(mk) |-> mk[*8] ##1 !mk) else $error("marker not one port period");
  AST_MARK_NO_WIN: assert property (
    mk |-> !win) else $error("marker overlaps window");
  AST_QUIET_AFTER_RESET: assert property (
    $rose(nrst) |-> (!win && !mk)[*8]) else $error("port active right after reset");
  AST_OTHER_STS_PASS: assert property (
    tx_valid && tx_sts_sel != 2'h0 |=> tx_out_valid && tx_out_data == $past(tx_data))
    else $error("other channel byte altered");
  AST_NON_TOH_PASS: assert property (
    tx_valid && !tx_toh_byte |=> tx_out_data == $past(tx_data))
    else $error("payload byte altered");
endmodule
bind toip_top toip_checker toip_checker_i (.clk_sys(clk_sys), .nrst(nrst),
  .overhead_port_clock(overhead_port_clock), .overhead_accept_window(overhead_accept_window),
  .overhead_frame_marker(overhead_frame_marker), .tx_valid(tx_valid),
  .tx_toh_byte(tx_toh_byte), .tx_sts_sel(tx_sts_sel), .tx_data(tx_data),
  .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data));
`default_nettype wire

// *** test/toip_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module toip_partner (
  input  wire logic       pclk,
  input  wire logic       win,
  input  wire logic       mark,
  input  wire logic       go,
  input  wire logic [7:0] pat,
  output var  logic       sin,
  output var  logic       req
);
  logic       at_frame;
  logic [2:0] idx;
  initial begin
    sin = 1'b0;
    req = 1'b0;
    idx = 3'h0;
    at_frame = 1'b0;
  end
  // Request answers the window seen at this rise, before the capture
  always @(posedge pclk) begin
    at_frame <= mark;
    req      <= go & win;
  end
  // Bit for the next slot goes out at this fall; count restarts at the marker
  always @(negedge pclk) begin
    sin <= go ? pat[3'h7 - (at_frame ? 3'h0 : idx)] : ~sin;
    idx <= (at_frame ? 3'h0 : idx) + 3'h1;
  end
endmodule
`default_nettype wire

// *** test/toip_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end
module toip_top_bench;
  logic       clk_sys, nrst, pclk, win, mark, sin, req, go, tx_frame_start;
  logic       tx_valid, tx_toh_byte, tx_out_valid;
  logic [1:0] tx_sts_sel;
  logic [4:0] tx_toh_idx;
  logic [7:0] tx_data, tx_out_data;
  int         fails, check_count, n;
  toip_top toip_top_inst (.clk_sys(clk_sys), .nrst(nrst), .overhead_port_clock(pclk),
    .overhead_accept_window(win), .overhead_frame_marker(mark), .overhead_serial_in(sin),
    .overhead_insert_request(req), .tx_frame_start(tx_frame_start), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_toh_byte(tx_toh_byte), .tx_sts_sel(tx_sts_sel),
    .tx_toh_idx(tx_toh_idx), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data));
  toip_partner toip_partner_i (.pclk(pclk), .win(win), .mark(mark), .go(go),
    .pat(8'hA5), .sin(sin), .req(req));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(int k);
    repeat (k) @(posedge clk_sys);
    #5;
  endtask
  task automatic wait_mark;
    n = 0;
    while (mark !== 1'b1 && n < 3000) begin n++; tick(1); end
    while (mark !== 1'b0 && n < 3000) begin n++; tick(1); end
    `CHK(n < 3000, 1'b1)
  endtask
  task automatic count_win(int exp);
    n = 0;
    repeat (1800) begin n += (win | mark); tick(1); end
    `CHK(n, exp)
  endtask
  task automatic byte_out(bit toh, bit [1:0] sts, bit [4:0] idx, bit [7:0] exp);
    tx_valid = 1'b1;
    tx_toh_byte = toh;
    tx_sts_sel = sts;
    tx_toh_idx = idx;
    tx_data = 8'h3C;
    tick(1);
    `CHK({tx_out_valid, tx_out_data}, {1'b1, exp})
  endtask
  // Other channel and payload bytes first: they must not pop the buffer head
  task automatic drain(bit [7:0] exp);
    for (bit [4:0] k = 0; k < 8; k++) begin
      byte_out(1'b0, 2'h0, k, 8'h3C);
      byte_out(1'b1, k[0] ? 2'h2 : 2'h1, k, 8'h3C);
      byte_out(1'b1, 2'h0, k, exp);
    end
    byte_out(1'b1, 2'h0, 5'h08, 8'h3C);
    tx_valid = 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Run is near 6.1k cycles; 20k cycles, over three times that, is a hang
  initial begin
    #1000000;
    fails++;
    complete_run;
  end
  initial begin
    {nrst, go, tx_frame_start, tx_valid, tx_toh_byte} = 5'b01000;
    {tx_sts_sel, tx_toh_idx, tx_data, fails, check_count} = '0;
    tick(4);
    nrst = 1'b1;
    count_win(0);
    $display("test quiet_after_reset done");
    tx_frame_start = 1'b1;
    tick(1);
    tx_frame_start = 1'b0;
    wait_mark;
    count_win(512);
    drain(8'hA5);
    $display("test insert_full_buffer done");
    go = 1'b0;
    wait_mark;
    count_win(1728);
    drain(8'h3C);
    $display("test request_low done");
    complete_run;
  end
endmodule
`default_nettype wire
